// file: design/wakeup_timer_map.svh
// Register byte addresses, field positions, reset values and timing figures of the wake-up timer
`ifndef WAKEUP_TIMER_MAP_SVH
`define WAKEUP_TIMER_MAP_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define WT_ADDR_CONTROL       32'h40002500
`define WT_ADDR_ENABLE        32'h40002504
`define WT_ADDR_MATCH_ENABLE  32'h40002528
`define WT_ADDR_FLAG_STATUS   32'h4000252c
`define WT_ADDR_FLAG_CLEAR    32'h40002530
`define WT_ADDR_CAPTURE_LOW   32'h4000253c
`define WT_ADDR_CAPTURE_HIGH  32'h40002540
`define WT_ADDR_COUNT_LOW     32'h40002544
`define WT_ADDR_COUNT_HIGH    32'h40002548
`define WT_ADDR_IRQ_MASK      32'h4000254c

// ****************************************************************
// Field positions
// ****************************************************************
`define WT_ST_MATCH_A   0
`define WT_ST_MATCH_B   1
`define WT_ST_MATCH_C   2
`define WT_ST_ROLL      3
`define WT_ST_CAPTURE   4
`define WT_ST_WAKE      6
`define WT_ST_FREEZE    7
`define WT_ST_EN_SYNC   8
`define WT_CLR_CAPTURE  4
`define WT_CLR_W        5
`define WT_IRQ_W        5
`define WT_CTL_FREE_RUN 0
`define WT_CTL_DOWN     1
`define WT_CTL_FREEZE   3
`define WT_CTL_SEL_LO   4
`define WT_CTL_SEL_HI   5
`define WT_EN_BIT       0
`define WT_MATCH_W      3

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define WT_RESET_WORD   16'h0000
`define WT_CORE_HZ      125000000
`define WT_SLOW_HZ      32768
`define WT_TICK_CYCLES  (`WT_CORE_HZ / `WT_SLOW_HZ)

`endif

// file: design/wakeup_timer_pkg.sv
// Shared types of the wake-up timer status and capture block
package wakeup_timer_pkg;
    typedef logic [31:0] bus_addr_type;
    typedef logic [15:0] reg_word_type;
    typedef logic [1:0]  event_sel_type;
    typedef enum logic [1:0] {
        COUNT_UP_TYPE   = 2'b01,
        COUNT_DOWN_TYPE = 2'b10
    } count_dir_type;
endpackage : wakeup_timer_pkg

// file: design/wakeup_timer_status_capture.sv
// Wake-up timer: status flags, flag clearing, count capture and register slave
//
// Summary of operation
// (RULE1) Enable write sets enable-sync pending bit 8; the code sets it only on a write that changes the enable
// (RULE2) Pending bit clears once enable reaches tick
// (RULE3) Status bit 7 shows upper half frozen
// (RULE4) Status bit 6 is the wake-up request
// (RULE5) Event rising edge captures count, sets bit 4
// (RULE6) Upper capture read clears capture flag
// (RULE7) Free-run rollover at all ones or zeros
// (RULE8) Rollover flag cleared only by clear register
// (RULE9) Enabled comparator hits set bits 0 to 2
// (RULE10) Status read clears match flags
// (RULE11) Clear bits 0-3 clear match and rollover
// (RULE12) Clear bits self-clear after timer tick
// (RULE13) Clear bit 4 clears capture flag
// (RULE14) Software writes zero to clear bits 15:5
// (RULE15) Software completes clear write before return
// (RULE16) Capture pair holds low then high half
// (RULE17) Software waits sync idle before reprogramming
// (RULE18) Enable low holds timer in reset
// (RULE19) Snapshot and flag update in same tick
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_map.svh"

module wakeup_timer_status_capture #(
    parameter int unsigned TICK_CYCLES = `WT_TICK_CYCLES,
    parameter int unsigned EVENT_LINES = 4,
    parameter int unsigned SYNC_STAGES = 3
) (
    input  wire logic                          core_clk_i,
    input  wire logic                          rst_n_i,
    input  wire wakeup_timer_pkg::bus_addr_type addr_i,
    input  wire wakeup_timer_pkg::reg_word_type wr_data_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output var  wakeup_timer_pkg::reg_word_type rd_data_o,
    input  wire logic [EVENT_LINES-1:0]        event_lines_i,
    input  wire logic                          match_a_hit_i,
    input  wire logic                          match_b_hit_i,
    input  wire logic                          match_c_hit_i,
    output logic                               wakeup_req_o,
    output logic                               irq_o,
    output logic [31:0]                        count_o
);
    import wakeup_timer_pkg::*;

    localparam int unsigned DIV_W = $clog2(TICK_CYCLES + 1);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    reg_word_type                  timer_control_reg;
    logic                          timer_enable_reg;
    logic [`WT_MATCH_W-1:0]        match_enable_reg;
    logic [`WT_IRQ_W-1:0]          irq_mask;
    logic [`WT_CLR_W-1:0]          flag_clear_reg;
    logic                          timer_run;
    logic                          en_sync_pending;
    logic                          match_a_flag;
    logic                          match_b_flag;
    logic                          match_c_flag;
    logic                          roll_flag;
    logic                          capture_flag;
    logic                          frozen;
    reg_word_type                  count_upper_half;
    reg_word_type                  capture_lower_half;
    reg_word_type                  capture_upper_half;
    logic [31:0]                   count;
    logic [DIV_W-1:0]              div_count;
    logic                          tick;
    logic                          event_armed;
    logic [SYNC_STAGES-1:0]        event_sync [EVENT_LINES];
    logic                          event_level [EVENT_LINES];
    logic [EVENT_LINES-1:0]        event_rise;

    logic                          wr_control;
    logic                          wr_enable;
    logic                          wr_match_en;
    logic                          wr_clear;
    logic                          wr_mask;
    logic                          rd_status;
    logic                          rd_cap_high;
    logic                          rd_count_low;
    logic                          rd_count_high;
    logic                          free_run;
    logic                          freeze_en;
    count_dir_type                 count_dir;
    event_sel_type                 event_sel;
    logic                          roll_hit;
    reg_word_type                  status_word;
    reg_word_type                  next_rd_data;

    assign wr_control    = wr_i && (addr_i == `WT_ADDR_CONTROL);
    assign wr_enable     = wr_i && (addr_i == `WT_ADDR_ENABLE);
    assign wr_match_en   = wr_i && (addr_i == `WT_ADDR_MATCH_ENABLE);
    assign wr_clear      = wr_i && (addr_i == `WT_ADDR_FLAG_CLEAR);
    assign wr_mask       = wr_i && (addr_i == `WT_ADDR_IRQ_MASK);
    assign rd_status     = rd_i && (addr_i == `WT_ADDR_FLAG_STATUS);
    assign rd_cap_high   = rd_i && (addr_i == `WT_ADDR_CAPTURE_HIGH);
    assign rd_count_low  = rd_i && (addr_i == `WT_ADDR_COUNT_LOW);
    assign rd_count_high = rd_i && (addr_i == `WT_ADDR_COUNT_HIGH);

    assign free_run  = timer_control_reg[`WT_CTL_FREE_RUN];
    assign freeze_en = timer_control_reg[`WT_CTL_FREEZE];
    assign count_dir = timer_control_reg[`WT_CTL_DOWN] ? COUNT_DOWN_TYPE : COUNT_UP_TYPE;
    assign event_sel = timer_control_reg[`WT_CTL_SEL_HI:`WT_CTL_SEL_LO];

    // ****************************************************************
    // Slow timer tick
    // ****************************************************************
    // The 32 kHz domain is modelled as a one-cycle enable; "synchronised
    // into the timer domain" means taken on the next tick.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_count <= '0;
            tick      <= 1'b0;
        end else if (div_count == DIV_W'(TICK_CYCLES - 1)) begin
            div_count <= '0;
            tick      <= 1'b1;
        end else begin
            div_count <= div_count + DIV_W'(1);
            tick      <= 1'b0;
        end
    end

    // ****************************************************************
    // Event line synchronisers
    // ****************************************************************
    generate
        for (genvar i = 0; i < EVENT_LINES; i++) begin : g_event
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    event_sync[i]  <= '0;
                    event_level[i] <= 1'b0;
                end else begin
                    event_sync[i] <= {event_sync[i][SYNC_STAGES-2:0], event_lines_i[i]};
                    // Level moves only once the last two stages agree
                    if (event_sync[i][SYNC_STAGES-1] == event_sync[i][SYNC_STAGES-2]) begin
                        event_level[i] <= event_sync[i][SYNC_STAGES-1];
                    end
                end
            end
            assign event_rise[i] = event_sync[i][SYNC_STAGES-1]
                                   && event_sync[i][SYNC_STAGES-2]
                                   && !event_level[i];
        end
    endgenerate

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_control_reg <= `WT_RESET_WORD;
            match_enable_reg  <= '0;
            irq_mask          <= '0;
        end else begin
            if (wr_control) begin
                timer_control_reg <= wr_data_i;
            end
            if (wr_match_en) begin
                match_enable_reg <= wr_data_i[`WT_MATCH_W-1:0];
            end
            if (wr_mask) begin
                irq_mask <= wr_data_i[`WT_IRQ_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Enable and its synchronisation
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_enable_reg <= 1'b0;
            timer_run        <= 1'b0;
            en_sync_pending  <= 1'b0;
        end else begin
            if (wr_enable) begin
                timer_enable_reg <= wr_data_i[`WT_EN_BIT];
            end
            if (tick) begin
                timer_run <= timer_enable_reg;
            end
            // (RULE1) set on enable change
            if (wr_enable && (wr_data_i[`WT_EN_BIT] != timer_enable_reg)) begin
                en_sync_pending <= 1'b1;
            // (RULE2) clear after tick
            end else if (tick) begin
                en_sync_pending <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    assign roll_hit = free_run && timer_run
                      && (((count_dir == COUNT_UP_TYPE) && (&count))
                          || ((count_dir == COUNT_DOWN_TYPE) && (count == '0)));

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
        end else if (tick) begin
            // (RULE18) disabled timer held in reset
            if (!timer_run) begin
                count <= '0;
            end else if (!free_run && match_c_hit_i) begin
                count <= '0;
            end else if (count_dir == COUNT_DOWN_TYPE) begin
                count <= count - 32'h00000001;
            end else begin
                count <= count + 32'h00000001;
            end
        end
    end

    // ****************************************************************
    // Freeze of the upper count half
    // ****************************************************************
    // Reading the low half pins the high half, so a two-read fetch of the
    // count cannot tear across a carry.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            frozen           <= 1'b0;
            count_upper_half <= `WT_RESET_WORD;
        end else if (!freeze_en) begin
            frozen <= 1'b0;
        // (RULE3) freeze on low read
        end else if (rd_count_low) begin
            frozen           <= 1'b1;
            count_upper_half <= count[31:16];
        end else if (rd_count_high) begin
            frozen <= 1'b0;
        end
    end

    // ****************************************************************
    // Clear register
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_clear_reg <= '0;
        end else begin
            // (RULE12) self-clear after tick
            if (tick) begin
                flag_clear_reg <= '0;
            end
            // Upper bits ignored; bits applied on this tick are not re-armed
            if (wr_clear) begin
                flag_clear_reg <= (tick ? '0 : flag_clear_reg) | wr_data_i[`WT_CLR_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Match and rollover flags
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            match_a_flag <= 1'b0;
            match_b_flag <= 1'b0;
            match_c_flag <= 1'b0;
        end else begin
            // (RULE10) status read clears
            if (rd_status) begin
                match_a_flag <= 1'b0;
                match_b_flag <= 1'b0;
                match_c_flag <= 1'b0;
            end
            // (RULE11) clear on tick
            if (tick && flag_clear_reg[`WT_ST_MATCH_A]) begin
                match_a_flag <= 1'b0;
            end
            if (tick && flag_clear_reg[`WT_ST_MATCH_B]) begin
                match_b_flag <= 1'b0;
            end
            if (tick && flag_clear_reg[`WT_ST_MATCH_C]) begin
                match_c_flag <= 1'b0;
            end
            // (RULE9) enabled hits set, set wins
            if (match_a_hit_i && match_enable_reg[`WT_ST_MATCH_A]) begin
                match_a_flag <= 1'b1;
            end
            if (match_b_hit_i && match_enable_reg[`WT_ST_MATCH_B]) begin
                match_b_flag <= 1'b1;
            end
            if (match_c_hit_i && match_enable_reg[`WT_ST_MATCH_C]) begin
                match_c_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            roll_flag <= 1'b0;
        end else if (tick) begin
            // (RULE7) set on rollover
            if (roll_hit) begin
                roll_flag <= 1'b1;
            // (RULE8) clear register only
            end else if (flag_clear_reg[`WT_ST_ROLL]) begin
                roll_flag <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Capture
    // ****************************************************************
    // An edge between ticks is held until the tick, so the count taken is
    // the one of the tick and both halves belong together.
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_armed <= 1'b0;
        end else if (event_rise[event_sel]) begin
            event_armed <= 1'b1;
        end else if (tick) begin
            event_armed <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_flag       <= 1'b0;
            capture_lower_half <= `WT_RESET_WORD;
            capture_upper_half <= `WT_RESET_WORD;
        end else begin
            // (RULE6) high read clears
            if (rd_cap_high) begin
                capture_flag <= 1'b0;
            end
            // (RULE13) clear bit 4
            if (tick && flag_clear_reg[`WT_CLR_CAPTURE]) begin
                capture_flag <= 1'b0;
            end
            // (RULE5) capture and flag
            if (tick && event_armed) begin
                // (RULE19) snapshot with flag
                capture_flag       <= 1'b1;
                // (RULE16) low and high halves
                capture_lower_half <= count[15:0];
                capture_upper_half <= count[31:16];
            end
        end
    end

    // ****************************************************************
    // Status word and read port
    // ****************************************************************
    always_comb begin
        status_word                  = `WT_RESET_WORD;
        status_word[`WT_ST_MATCH_A]  = match_a_flag;
        status_word[`WT_ST_MATCH_B]  = match_b_flag;
        status_word[`WT_ST_MATCH_C]  = match_c_flag;
        status_word[`WT_ST_ROLL]     = roll_flag;
        status_word[`WT_ST_CAPTURE]  = capture_flag;
        status_word[`WT_ST_WAKE]     = wakeup_req_o;
        status_word[`WT_ST_FREEZE]   = frozen && freeze_en;
        status_word[`WT_ST_EN_SYNC]  = en_sync_pending;
    end

    always_comb begin
        next_rd_data = `WT_RESET_WORD;
        if (rd_i) begin
            unique case (addr_i)
                `WT_ADDR_CONTROL:      next_rd_data = timer_control_reg;
                `WT_ADDR_ENABLE:       next_rd_data = {15'h0000, timer_enable_reg};
                `WT_ADDR_MATCH_ENABLE: next_rd_data = {13'h0000, match_enable_reg};
                `WT_ADDR_FLAG_STATUS:  next_rd_data = status_word;
                `WT_ADDR_CAPTURE_LOW:  next_rd_data = capture_lower_half;
                `WT_ADDR_CAPTURE_HIGH: next_rd_data = capture_upper_half;
                `WT_ADDR_COUNT_LOW:    next_rd_data = count[15:0];
                `WT_ADDR_COUNT_HIGH:   next_rd_data = frozen ? count_upper_half : count[31:16];
                `WT_ADDR_IRQ_MASK:     next_rd_data = {11'h000, irq_mask};
                // Clear register is write-only; unmapped reads return zero
                default:               next_rd_data = `WT_RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= `WT_RESET_WORD;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wakeup_req_o <= 1'b0;
            irq_o        <= 1'b0;
            count_o      <= '0;
        end else begin
            // (RULE4) wake request while any flag set
            wakeup_req_o <= match_a_flag || match_b_flag || match_c_flag
                            || roll_flag || capture_flag || en_sync_pending;
            irq_o        <= |(status_word[`WT_IRQ_W-1:0] & irq_mask);
            count_o      <= count;
        end
    end

endmodule : wakeup_timer_status_capture
`default_nettype wire

// file: tb/wakeup_timer_status_capture_asserts.sv
// Port-level checker for the wake-up timer status and capture block
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_map.svh"
// ********************************
// Checker
// ********************************
module wakeup_timer_status_capture_asserts #(
    parameter int unsigned TICK_CYCLES = 8,
    parameter int unsigned EVENT_LINES = 4
) (
    input wire logic                           core_clk_i,
    input wire logic                           rst_n_i,
    input wire wakeup_timer_pkg::bus_addr_type addr_i,
    input wire wakeup_timer_pkg::reg_word_type wr_data_i,
    input wire logic                           wr_i,
    input wire logic                           rd_i,
    input wire wakeup_timer_pkg::reg_word_type rd_data_o,
    input wire logic [EVENT_LINES-1:0]         event_lines_i,
    input wire logic                           match_a_hit_i,
    input wire logic                           match_b_hit_i,
    input wire logic                           match_c_hit_i,
    input wire logic                           wakeup_req_o,
    input wire logic                           irq_o,
    input wire logic [31:0]                    count_o
);
    import wakeup_timer_pkg::*;
    // Two ticks of margin: the enable crosses on a tick and the count lags it
    localparam int unsigned SETTLE = 2 * TICK_CYCLES + 4;
    logic        en_seen;
    logic        frz_seen;
    logic [15:0] since_en;
    wire logic   wr_en  = wr_i && addr_i == `WT_ADDR_ENABLE;
    wire logic   rd_st  = rd_i && addr_i == `WT_ADDR_FLAG_STATUS;
    wire logic   no_hit = !(match_a_hit_i || match_b_hit_i || match_c_hit_i);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_seen  <= 1'b0;
            frz_seen <= 1'b0;
            since_en <= 16'h0000;
        end else begin
            if (wr_en) begin
                en_seen <= wr_data_i[0];
            end
            if (wr_i && addr_i == `WT_ADDR_CONTROL) begin
                frz_seen <= wr_data_i[3];
            end
            since_en <= wr_en ? 16'h0000 : (since_en == 16'hffff ? since_en : since_en + 16'h0001);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_en_sync_set: assert property (wr_en && wr_data_i[0] != en_seen |-> ##[1:3] wakeup_req_o)
        else $error("wake not raised");
    chk_en_sync_done: assert property (rd_st && since_en > SETTLE |=> !rd_data_o[8])
        else $error("sync stuck");
    chk_count_held: assert property (!en_seen && since_en > SETTLE |-> count_o == 32'h0)
        else $error("count moved");
    chk_match_read_clr: assert property (rd_st && no_hit ##1 rd_st && no_hit |=> rd_data_o[2:0] == 3'h0)
        else $error("match kept");
    chk_wake_flags: assert property (rd_st |=> (rd_data_o[8] || |rd_data_o[4:0]) == wakeup_req_o)
        else $error("wake mismatch");
    chk_irq_wake: assert property (irq_o |-> wakeup_req_o)
        else $error("irq without wake");
    chk_clear_reads_zero: assert property (rd_i && addr_i == `WT_ADDR_FLAG_CLEAR |=> rd_data_o == 16'h0)
        else $error("clear reads nonzero");
    chk_freeze_off: assert property (rd_st && !frz_seen |=> !rd_data_o[7])
        else $error("freeze while off");
endmodule : wakeup_timer_status_capture_asserts

bind wakeup_timer_status_capture wakeup_timer_status_capture_asserts #(
    .TICK_CYCLES(TICK_CYCLES), .EVENT_LINES(EVENT_LINES)
) chk_u (.*);
`default_nettype wire

// file: tb/wakeup_timer_status_capture_tb_top.sv
// Self-checking bench for the wake-up timer status and capture block
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_timer_map.svh"
// ********************************
// Bench
// ********************************
module wakeup_timer_status_capture_tb_top;
    import wakeup_timer_pkg::*;
    localparam int unsigned TICK = 8;
    localparam int unsigned WAIT_CLR = 2 * TICK + 2;
    typedef struct {reg_word_type val; reg_word_type msk;} note_type;
    logic         core_clk_i = 1'b0;
    logic         rst_n_i    = 1'b0;
    bus_addr_type addr_i     = '0;
    reg_word_type wr_data_i  = '0;
    logic         wr_i       = 1'b0;
    logic         rd_i       = 1'b0;
    logic [3:0]   ev_lines   = '0;
    logic [2:0]   hits       = '0;
    reg_word_type rd_data_o;
    logic         wakeup_req_o;
    logic         irq_o;
    logic [31:0]  count_o;
    logic         rd_seen    = 1'b0;
    note_type     notes[$];
    int           errors     = 0;
    int           checks     = 0;
    wakeup_timer_status_capture #(.TICK_CYCLES(TICK)) dut_u (.event_lines_i(ev_lines),
        .match_a_hit_i(hits[0]), .match_b_hit_i(hits[1]), .match_c_hit_i(hits[2]), .*);
    initial begin
        forever #4 core_clk_i = ~core_clk_i;
    end
    task automatic end_sim();
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask : wt
    task automatic wr(input bus_addr_type a, input reg_word_type d);
        wt(1);
        wr_i      <= 1'b1;
        addr_i    <= a;
        wr_data_i <= d;
        wt(1);
        wr_i <= 1'b0;
    endtask : wr
    // Optional back-to-back second read catches read side effects
    task automatic rd(input bus_addr_type a, input reg_word_type v,
                      input reg_word_type m = 16'hffff, input bit two = 1'b0,
                      input reg_word_type v2 = 16'h0);
        wt(1);
        rd_i   <= 1'b1;
        addr_i <= a;
        notes.push_back('{v, m});
        if (two) begin
            wt(1);
            notes.push_back('{v2, m});
        end
        wt(1);
        rd_i <= 1'b0;
    endtask : rd
    task automatic pulse(input int i);
        wt(1);
        hits[i] <= 1'b1;
        wt(1);
        hits[i] <= 1'b0;
        wt(2);
    endtask : pulse
    // Read data stand one cycle after the strobe
    always @(posedge core_clk_i) begin
        rd_seen <= rd_i;
        if (rd_seen) begin
            cmp("note", 32'h1, {31'h0, notes.size() != 0});
            if (notes.size() != 0) begin
                cmp("read", {16'h0, notes[0].val}, {16'h0, rd_data_o & notes[0].msk});
                void'(notes.pop_front());
            end
        end
    end
    initial begin
        wt(20000);
        errors++;
        end_sim();
    end
    initial begin
        void'($urandom(99));
        wt(16);
        rst_n_i <= 1'b1;
        rd(`WT_ADDR_FLAG_STATUS, 16'h0);
        rd(`WT_ADDR_CAPTURE_LOW, 16'h0);
        rd(`WT_ADDR_CAPTURE_HIGH, 16'h0);
        wr(32'h40002534, 16'($urandom));
        rd(32'h40002534, 16'h0);
        wr(`WT_ADDR_CONTROL, 16'h0001);
        wr(`WT_ADDR_MATCH_ENABLE, 16'h0007);
        wr(`WT_ADDR_IRQ_MASK, 16'h001f);
        wr(`WT_ADDR_ENABLE, 16'h0001);
        rd(`WT_ADDR_FLAG_STATUS, 16'h0100, 16'h0100);
        wt(3 * TICK);
        rd(`WT_ADDR_FLAG_STATUS, 16'h0000, 16'h0100);
        cmp("count running", 32'h1, {31'h0, count_o != 32'h0});
        for (int i = 0; i < 3; i++) begin
            pulse(i);
            cmp("irq set", 32'h1, {31'h0, irq_o});
            wr(`WT_ADDR_FLAG_CLEAR, 16'h0001 << i);
            wt(WAIT_CLR);
            rd(`WT_ADDR_FLAG_STATUS, 16'h0, 16'h000f);
            cmp("irq cleared", 32'h0, {31'h0, irq_o});
        end
        rd(`WT_ADDR_FLAG_CLEAR, 16'h0);
        pulse(2);
        rd(`WT_ADDR_FLAG_STATUS, 16'h0004, 16'h0007, 1'b1);
        wr(`WT_ADDR_IRQ_MASK, 16'h0000);
        pulse(1);
        cmp("irq masked", 32'h0, {31'h0, irq_o});
        wr(`WT_ADDR_FLAG_CLEAR, 16'h0000);
        wr(`WT_ADDR_IRQ_MASK, 16'h001f);
        wt(WAIT_CLR);
        cmp("irq unmasked", 32'h1, {31'h0, irq_o});
        rd(`WT_ADDR_FLAG_STATUS, 16'h0002, 16'h0007, 1'b1);
        wr(`WT_ADDR_MATCH_ENABLE, 16'h0000);
        pulse(0);
        rd(`WT_ADDR_FLAG_STATUS, 16'h0, 16'h0007);
        for (int k = 0; k < 2; k++) begin
            ev_lines <= {3'($urandom), 1'b0};
            wt(3 * TICK);
            ev_lines[0] <= 1'b1;
            wt(3 * TICK);
            rd(`WT_ADDR_FLAG_STATUS, 16'h0010, 16'h0010);
            cmp("irq capture", 32'h1, {31'h0, irq_o});
            if (k == 0) begin
                rd(`WT_ADDR_CAPTURE_HIGH, 16'h0, 16'h0);
                rd(`WT_ADDR_FLAG_STATUS, 16'h0, 16'h0010);
            end else begin
                wr(`WT_ADDR_FLAG_CLEAR, 16'h0010);
                wt(WAIT_CLR);
                rd(`WT_ADDR_FLAG_STATUS, 16'h0, 16'h0010);
            end
        end
        wt(2);
        cmp("wake idle", 32'h0, {31'h0, wakeup_req_o});
        wr(`WT_ADDR_ENABLE, 16'h0000);
        rd(`WT_ADDR_FLAG_STATUS, 16'h0100, 16'h0100);
        wt(WAIT_CLR + 4);
        cmp("count reset", 32'h0, count_o);
        cmp("notes left", 32'h0, notes.size());
        end_sim();
    end
endmodule : wakeup_timer_status_capture_tb_top
`default_nettype wire
